//--- wonm_top.v
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "wonm_consts.vh"

module wonm_top #(
  parameter ADDR_W = 12
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire rxSof,
  input wire rxEof,
  input wire rxDaStrobe,
  input wire [7:0] rxByte,
  input wire rxDaOwn,
  input wire rxDaMulti,
  input wire rxDaBcast,
  input wire rxFcsOk,
  input wire rxIpCsumOk,
  input wire rxL4CsumOk,
  input wire rxIsArp,
  input wire rxIsNs,
  input wire rxIsV4Syn,
  input wire rxIsV6Syn,
  input wire arpTargetOk,
  input wire nsTargetOk,
  input wire synAddrOk,
  input wire [127:0] nsTargetAddr,
  input wire resumeDone,
  output wire wakeReq,
  output wire arpAnswerReq,
  output wire nsAnswerReq,
  output wire fwdPass,
  output wire fwdDrop,
  output wire [1:0] nsSetHit,
  output wire [127:0] naSourceAddr
);
  localparam [3:0] SEL_CTRL = 4'h0;
  localparam [3:0] SEL_AUX = 4'h1;
  localparam [3:0] SEL_NONE = 4'hF;
  // register slot decode, shared by the read and write paths
  function [3:0] decodeReg;
    input [ADDR_W-1:0] a;
    begin
      if (a[1:0] != 2'h0)
        decodeReg = SEL_NONE;
      else if (a == `WONM_OFS_CTRL)
        decodeReg = SEL_CTRL;
      else if (a == `WONM_OFS_AUX)
        decodeReg = SEL_AUX;
      else if (a[ADDR_W-1:4] == `WONM_NS0_PAGE)
        decodeReg = {2'h0, a[3:2]} + 4'h2;
      else if (a[ADDR_W-1:4] == `WONM_NS1_PAGE)
        decodeReg = {2'h0, a[3:2]} + 4'h6;
      else
        decodeReg = SEL_NONE;
    end
  endfunction
  // expand byte strobes into a bit mask
  function [31:0] laneMask;
    input [3:0] strb;
    begin
      laneMask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction
  // reset release through two flops; assertion stays asynchronous
  reg rstSync1_r, rstSync2_r;
  wire rstN;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1_r <= 1'b0;
      rstSync2_r <= 1'b0;
    end else begin
      rstSync1_r <= 1'b1;
      rstSync2_r <= rstSync1_r;
    end
  end
  assign rstN = rstSync2_r;
  // register storage
  reg [31:0] ctrl_r, ctrl_nxt, aux_r;
  reg [31:0] nsAddr_r [0:7];
  // write channel state; ready flops double as "slot empty"
  reg awReady_r, wReady_r, bValid_r;
  reg [1:0] bResp_r;
  reg [ADDR_W-1:0] wAddr_r;
  reg [31:0] wData_r;
  reg [3:0] wStrb_r;
  wire doWrite;
  wire [3:0] wSel;
  wire [31:0] wMask;
  assign doWrite = !awReady_r && !wReady_r && !bValid_r;
  assign wSel = decodeReg(wAddr_r);
  assign wMask = laneMask(wStrb_r);
  // address and data taken in either order, response after both
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      awReady_r <= 1'b1;
      wReady_r <= 1'b1;
      bValid_r <= 1'b0;
      bResp_r <= `WONM_RESP_OKAY;
      wAddr_r <= {ADDR_W{1'b0}};
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
    end else begin
      if (awReady_r && s_axi_awvalid) begin
        awReady_r <= 1'b0;
        wAddr_r <= s_axi_awaddr;
      end
      if (wReady_r && s_axi_wvalid) begin
        wReady_r <= 1'b0;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        bValid_r <= 1'b1;
        bResp_r <= (wSel == SEL_NONE) ? `WONM_RESP_SLVERR : `WONM_RESP_OKAY;
      end
      if (bValid_r && s_axi_bready) begin
        bValid_r <= 1'b0;
        awReady_r <= 1'b1;
        wReady_r <= 1'b1;
      end
    end
  end
  // read channel: data one cycle after the address is taken
  reg arReady_r, rValid_r;
  reg [1:0] rResp_r;
  reg [31:0] rData_r, rdMux;
  reg [ADDR_W-1:0] rAddr_r;
  wire [3:0] rSel;
  assign rSel = decodeReg(rAddr_r);
  // register read select
  always @* begin
    rdMux = 32'h0000_0000;
    case (rSel)
      SEL_CTRL: rdMux = ctrl_r;
      SEL_AUX: rdMux = aux_r;
      SEL_NONE: rdMux = 32'h0000_0000;
      default: rdMux = nsAddr_r[rSel[2:0] - 3'h2];
    endcase
  end
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      arReady_r <= 1'b1;
      rValid_r <= 1'b0;
      rResp_r <= `WONM_RESP_OKAY;
      rData_r <= 32'h0000_0000;
      rAddr_r <= {ADDR_W{1'b0}};
    end else begin
      if (arReady_r && s_axi_arvalid) begin
        arReady_r <= 1'b0;
        rAddr_r <= s_axi_araddr;
      end
      if (!arReady_r && !rValid_r) begin
        rValid_r <= 1'b1;
        rData_r <= rdMux;
        rResp_r <= (rSel == SEL_NONE) ? `WONM_RESP_SLVERR : `WONM_RESP_OKAY;
      end
      if (rValid_r && s_axi_rready) begin
        rValid_r <= 1'b0;
        arReady_r <= 1'b1;
      end
    end
  end
  // IPv6 destination collected from the receive stream
  wire [127:0] hdrDa;
  wire hdrDaDone;
  wonm_addr_capture daCap (
    .clk(ref_clk),
    .rstN(rstN),
    .frameStart(rxSof),
    .byteStrobe(rxDaStrobe),
    .byteIn(rxByte),
    .addr_r(hdrDa),
    .complete_r(hdrDaDone)
  );
  // low dword at the lowest offset
  wire [127:0] progSet0, progSet1;
  assign progSet0 = {nsAddr_r[3], nsAddr_r[2], nsAddr_r[1], nsAddr_r[0]};
  assign progSet1 = {nsAddr_r[7], nsAddr_r[6], nsAddr_r[5], nsAddr_r[4]};
  wire hit0, hit1;
  wonm_addr_match match0 (
    .hdrAddr(hdrDa),
    .progAddr(progSet0),
    .solicited(),
    .hit(hit0)
  );
  wonm_addr_match match1 (
    .hdrAddr(hdrDa),
    .progAddr(progSet1),
    .solicited(),
    .hit(hit1)
  );
  // frame qualification at end of frame
  wire daOk, csumGood, nsEn, arpEn, evNs, evArp, evV6, evV4;
  wire [1:0] setHit;
  assign daOk = rxDaOwn || rxDaMulti || rxDaBcast;
  assign csumGood = rxFcsOk &&
    (ctrl_r[`WONM_B_CSUM_OFF] || (rxIpCsumOk && rxL4CsumOk));
  assign nsEn = ctrl_r[`WONM_B_NS_EN];
  assign arpEn = ctrl_r[`WONM_B_ARP_EN];
  assign setHit = {hit1, hit0} & {2{hdrDaDone && nsEn}};
  assign evNs = rxEof && rxIsNs && daOk && csumGood && nsTargetOk && (setHit != 2'h0);
  assign evArp = rxEof && rxIsArp && daOk && csumGood && arpTargetOk;
  assign evV6 = rxEof && rxIsV6Syn && daOk && csumGood && synAddrOk;
  assign evV4 = rxEof && rxIsV4Syn && daOk && csumGood && synAddrOk;
  // control word next value: writes, resume clears, then hardware sets
  always @* begin
    ctrl_nxt = ctrl_r;
    if (doWrite && wSel == SEL_CTRL) begin
      ctrl_nxt = (ctrl_r & ~(`WONM_CTRL_WMASK & wMask)) |
                 (wData_r & `WONM_CTRL_WMASK & wMask);
      ctrl_nxt = ctrl_nxt & ~(wData_r & `WONM_CTRL_W1C & wMask);
    end
    if (resumeDone && aux_r[`WONM_B_RES_CLR_FLAGS]) begin
      ctrl_nxt[`WONM_B_V6_SEEN] = 1'b0;
      ctrl_nxt[`WONM_B_V4_SEEN] = 1'b0;
    end
    if (resumeDone && aux_r[`WONM_B_RES_CLR_EN]) begin
      ctrl_nxt[`WONM_B_V6_WAKE] = 1'b0;
      ctrl_nxt[`WONM_B_V4_WAKE] = 1'b0;
    end
    // set wins over any clear in the same cycle
    // NS seen
    if (evNs)
      ctrl_nxt[`WONM_B_NS_SEEN] = 1'b1;
    if (evArp)
      ctrl_nxt[`WONM_B_ARP_SEEN] = 1'b1;
    if (evV6)
      ctrl_nxt[`WONM_B_V6_SEEN] = 1'b1;
    if (evV4)
      ctrl_nxt[`WONM_B_V4_SEEN] = 1'b1;
  end
  integer i;
  // register file update; address words honour byte strobes
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      ctrl_r <= `WONM_CTRL_RST;
      aux_r <= `WONM_AUX_RST;
      for (i = 0; i < 8; i = i + 1) begin
        nsAddr_r[i] <= `WONM_ADDR_RST;
      end
    end else begin
      ctrl_r <= ctrl_nxt;
      if (doWrite && wSel == SEL_AUX) begin
        aux_r <= (aux_r & ~(`WONM_AUX_WMASK & wMask)) |
                 (wData_r & `WONM_AUX_WMASK & wMask);
      end
      if (doWrite && wSel != SEL_NONE && wSel != SEL_CTRL && wSel != SEL_AUX) begin
        nsAddr_r[wSel[2:0] - 3'h2] <= (nsAddr_r[wSel[2:0] - 3'h2] & ~wMask) |
                                      (wData_r & wMask);
      end
    end
  end
  // frame outcome pulses, one cycle after end of frame
  reg wakeReq_r, arpAnswer_r, nsAnswer_r, fwdPass_r, fwdDrop_r;
  reg [1:0] nsSetHit_r;
  reg [127:0] naSrc_r;
  wire arpHandled;
  assign arpHandled = evArp && arpEn;
  // outcome flops
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      wakeReq_r <= 1'b0;
      arpAnswer_r <= 1'b0;
      nsAnswer_r <= 1'b0;
      fwdPass_r <= 1'b0;
      fwdDrop_r <= 1'b0;
      nsSetHit_r <= 2'h0;
      naSrc_r <= 128'h0;
    end else begin
      wakeReq_r <= (evV6 && ctrl_r[`WONM_B_V6_WAKE]) ||
                   (evV4 && ctrl_r[`WONM_B_V4_WAKE]);
      arpAnswer_r <= arpHandled;
      nsAnswer_r <= evNs;
      fwdPass_r <= (arpHandled && ctrl_r[`WONM_B_FWD_ARP]) ||
                   (evNs && ctrl_r[`WONM_B_FWD_NS]);
      fwdDrop_r <= (arpHandled && !ctrl_r[`WONM_B_FWD_ARP]) ||
                   (evNs && !ctrl_r[`WONM_B_FWD_NS]);
      nsSetHit_r <= evNs ? setHit : 2'h0;
      if (evNs) begin
        // advert source select, set 0 preferred on double hit
        if (!ctrl_r[`WONM_B_NA_SEL])
          naSrc_r <= nsTargetAddr;
        else if (setHit[0])
          naSrc_r <= progSet0;
        else
          naSrc_r <= progSet1;
      end
    end
  end
  // all outputs straight from flops
  assign s_axi_awready = awReady_r;
  assign s_axi_wready = wReady_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;
  assign wakeReq = wakeReq_r;
  assign arpAnswerReq = arpAnswer_r;
  assign nsAnswerReq = nsAnswer_r;
  assign fwdPass = fwdPass_r;
  assign fwdDrop = fwdDrop_r;
  assign nsSetHit = nsSetHit_r;
  assign naSourceAddr = naSrc_r;

endmodule

//--- wonm_consts.vh
`ifndef WONM_CONSTS_VH
`define WONM_CONSTS_VH

// register byte offsets
`define WONM_OFS_CTRL 12'h600
`define WONM_OFS_AUX 12'h604
`define WONM_OFS_NS0 12'h610
`define WONM_OFS_NS1 12'h650
// upper address nibbles of the two destination address blocks
`define WONM_NS0_PAGE 8'h61
`define WONM_NS1_PAGE 8'h65

// reset values
`define WONM_CTRL_RST 32'h0000_0000
`define WONM_AUX_RST 32'h0000_0000
`define WONM_ADDR_RST 32'h0000_0000

// plain read/write bits and write-one-to-clear bits of the control word, then the writable bits of the auxiliary word
`define WONM_CTRL_WMASK 32'h8000_070F
`define WONM_CTRL_W1C 32'h0000_00F0
`define WONM_AUX_WMASK 32'h0000_0003

// control word bit positions
`define WONM_B_CSUM_OFF 31
`define WONM_B_FWD_ARP 10
`define WONM_B_FWD_NS 9
`define WONM_B_NA_SEL 8
`define WONM_B_NS_SEEN 7
`define WONM_B_ARP_SEEN 6
`define WONM_B_V6_SEEN 5
`define WONM_B_V4_SEEN 4
`define WONM_B_NS_EN 3
`define WONM_B_ARP_EN 2
`define WONM_B_V6_WAKE 1
`define WONM_B_V4_WAKE 0
// auxiliary word bit positions
`define WONM_B_RES_CLR_FLAGS 0
`define WONM_B_RES_CLR_EN 1

// solicited-node multicast prefix, FF02::1:FF00:0/104
`define WONM_SOL_PREFIX 104'hFF02_0000_0000_0000_0000_0001_FF
`define WONM_SOL_BITS 24
`define WONM_ADDR_BYTES 16

// AXI responses
`define WONM_RESP_OKAY 2'h0
`define WONM_RESP_SLVERR 2'h2

`endif

//--- wonm_addr_capture.v
`timescale 1ns/10ps
`include "wonm_consts.vh"

module wonm_addr_capture (
  input wire clk,
  input wire rstN,
  input wire frameStart,
  input wire byteStrobe,
  input wire [7:0] byteIn,
  output reg [127:0] addr_r,
  output reg complete_r
);

  reg [4:0] count_r;

  // first byte on the wire ends in [127:120], sixteenth in [7:0]
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      addr_r <= 128'h0;
      count_r <= 5'h00;
      complete_r <= 1'b0;
    end else if (frameStart) begin
      count_r <= 5'h00;
      complete_r <= 1'b0;
    end else if (byteStrobe && !complete_r) begin
      addr_r <= {addr_r[119:0], byteIn};
      count_r <= count_r + 5'h01;
      // extra strobes after the sixteenth are ignored
      complete_r <= (count_r == 5'd`WONM_ADDR_BYTES - 5'h01);
    end
  end

endmodule

//--- wonm_addr_match.v
`timescale 1ns/10ps
`include "wonm_consts.vh"

module wonm_addr_match (
  input wire [127:0] hdrAddr,
  input wire [127:0] progAddr,
  output wire solicited,
  output wire hit
);

  // solicited-node destinations only carry the low 24 bits of interest
  assign solicited = (hdrAddr[127:`WONM_SOL_BITS] == `WONM_SOL_PREFIX);
  assign hit = solicited ? (hdrAddr[`WONM_SOL_BITS-1:0] == progAddr[127:104])
                         : (hdrAddr == progAddr);

endmodule

//--- wonm_checker_properties.sv
`timescale 1ns/10ps
module wonm_checker (
  input wire ref_clk,
  input wire rst_n,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire rxEof,
  input wire rxFcsOk,
  input wire rxDaOwn,
  input wire rxDaMulti,
  input wire rxDaBcast,
  input wire rxIsArp,
  input wire rxIsNs,
  input wire rxIsV4Syn,
  input wire rxIsV6Syn,
  input wire arpTargetOk,
  input wire nsTargetOk,
  input wire synAddrOk,
  input wire wakeReq,
  input wire arpAnswerReq,
  input wire nsAnswerReq,
  input wire fwdPass,
  input wire fwdDrop,
  input wire [1:0] nsSetHit
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // every answer must trace back to the frame that ended one cycle earlier
  wire daOk = rxDaOwn | rxDaMulti | rxDaBcast;
  a_wake_has_syn: assert property (wakeReq |->
    $past(rxEof && synAddrOk && (rxIsV4Syn || rxIsV6Syn))) else $error("wake without syn");
  a_answer_needs_fcs: assert property ((wakeReq || arpAnswerReq || nsAnswerReq) |->
    $past(rxFcsOk)) else $error("answer with bad fcs");
  a_ns_needs_da: assert property (nsAnswerReq |->
    $past(rxEof && rxIsNs && nsTargetOk && daOk)) else $error("ns answer bad cause");
  a_arp_has_cause: assert property (arpAnswerReq |->
    $past(rxEof && rxIsArp && arpTargetOk && daOk)) else $error("arp answer bad cause");
  a_hit_with_answer: assert property (nsAnswerReq == (nsSetHit != 2'h0))
    else $error("set hit and answer disagree");
  a_fwd_one_way: assert property ((fwdPass || fwdDrop) |->
    (arpAnswerReq || nsAnswerReq) && !(fwdPass && fwdDrop)) else $error("bad forward");
  a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
endmodule
bind wonm_top wonm_checker chk_u (.*);

//--- wonm_rx_peer.sv
`timescale 1ns/10ps
module wonm_rx_peer (
  input wire ref_clk,
  output logic rxSof,
  output logic rxEof,
  output logic rxDaStrobe,
  output logic [7:0] rxByte,
  output wire rxDaOwn,
  output wire rxDaMulti,
  output wire rxDaBcast,
  output wire rxFcsOk,
  output wire rxIpCsumOk,
  output wire rxL4CsumOk,
  output wire rxIsArp,
  output wire rxIsNs,
  output wire rxIsV4Syn,
  output wire rxIsV6Syn,
  output wire arpTargetOk,
  output wire nsTargetOk,
  output wire synAddrOk,
  output logic [127:0] nsTargetAddr
);
  logic [12:0] qv;
  // qualifier bundle, in the bit order the bench packs it
  assign {rxDaOwn, rxDaMulti, rxDaBcast, rxFcsOk, rxIpCsumOk, rxL4CsumOk, rxIsArp, rxIsNs,
    rxIsV4Syn, rxIsV6Syn, arpTargetOk, nsTargetOk, synAddrOk} = qv;
  // idle: no strobes, lanes hold junk rather than a stale frame
  initial begin
    rxSof = 1'b0;
    rxEof = 1'b0;
    rxDaStrobe = 1'b0;
    rxByte = 8'hA5;
    qv = 13'h1555;
    nsTargetAddr = 128'h0;
  end
  // one frame: start, sixteen address bytes, end with qualifiers
  task frame(input logic [127:0] da, input logic [12:0] q, input logic [127:0] tg);
    integer i;
    begin
      @(posedge ref_clk);
      rxSof <= 1'b1;
      for (i = 15; i >= 0; i--) begin
        @(posedge ref_clk);
        rxSof <= 1'b0;
        rxDaStrobe <= 1'b1;
        rxByte <= da[8*i +: 8];
      end
      @(posedge ref_clk);
      rxDaStrobe <= 1'b0;
      rxByte <= ~rxByte;
      rxEof <= 1'b1;
      qv <= q;
      nsTargetAddr <= tg;
      // qualifiers are only meaningful with the end strobe, so scramble them after
      @(posedge ref_clk);
      rxEof <= 1'b0;
      qv <= ~q;
      nsTargetAddr <= ~tg;
    end
  endtask
endmodule

//--- testbench.sv
`timescale 1ns/10ps
`include "wonm_consts.vh"
module testbench;
  logic ref_clk, rst_n, resumeDone;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, ctrl, aux, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, nsSetHit;
  wire [31:0] s_axi_rdata;
  wire rxSof, rxEof, rxDaStrobe, rxDaOwn, rxDaMulti, rxDaBcast, rxFcsOk, rxIpCsumOk;
  wire rxL4CsumOk, rxIsArp, rxIsNs, rxIsV4Syn, rxIsV6Syn, arpTargetOk, nsTargetOk, synAddrOk;
  wire wakeReq, arpAnswerReq, nsAnswerReq, fwdPass, fwdDrop;
  wire [7:0] rxByte;
  wire [127:0] nsTargetAddr, naSourceAddr;
  logic [127:0] sets [2];
  logic [127:0] naExp, da;
  logic [1:0] rsp;
  logic [12:0] qRand;
  int error_cnt = 0, total_checks = 0, i, sel;

  wonm_top dut_u (.*);
  wonm_rx_peer peer_u (.*);

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task chk(input logic [127:0] seen, input logic [127:0] exp);
    begin
      total_checks++;
      if (seen !== exp) begin
        error_cnt++;
        $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask

  task give_verdict;
    begin
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // hang guard, well past the ~2k cycles the run needs
  initial begin
    #1000000;
    error_cnt++;
    give_verdict;
  end

  function automatic logic [1:0] resp_of(input logic [11:0] a);
    resp_of = ((a == `WONM_OFS_CTRL || a == `WONM_OFS_AUX || a[11:4] == `WONM_NS0_PAGE ||
      a[11:4] == `WONM_NS1_PAGE) && a[1:0] == 2'h0) ? `WONM_RESP_OKAY : `WONM_RESP_SLVERR;
  endfunction

  // write: both channels offered together, each dropped once taken
  task wr(input logic [11:0] a, input logic [31:0] d);
    begin
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
        @(posedge ref_clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      chk(s_axi_bresp, resp_of(a));
      if (resp_of(a) == `WONM_RESP_OKAY) begin
        if (a == `WONM_OFS_CTRL) begin
          ctrl = (ctrl & ~`WONM_CTRL_WMASK) | (d & `WONM_CTRL_WMASK);
          ctrl = ctrl & ~(d & `WONM_CTRL_W1C);
        end else if (a == `WONM_OFS_AUX) aux = d & `WONM_AUX_WMASK;
        else sets[a[6]][32*a[3:2] +: 32] = d;
      end
    end
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] exp);
    begin
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
        @(posedge ref_clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      chk(s_axi_rdata, exp);
      chk(s_axi_rresp, resp_of(a));
    end
  endtask

  // q bits: own multi bcast fcs ip l4 arp ns v4 v6 arpTgt nsTgt synOk
  task frm(input logic [127:0] d, input logic [12:0] q, input logic [127:0] tg);
    logic [1:0] hit;
    logic ok, nsOk, arpOk, v4, v6;
    begin
      peer_u.frame(d, q, tg);
      #1;
      ok = (|q[12:10]) && q[9] && (ctrl[31] || (q[8] && q[7]));
      for (int x = 0; x < 2; x++)
        hit[x] = (d[127:24] == `WONM_SOL_PREFIX) ? d[23:0] == sets[x][127:104] :
          d == sets[x];
      nsOk = ok && q[5] && q[1] && ctrl[3] && (|hit);
      arpOk = ok && q[6] && q[2];
      v4 = ok && q[4] && q[0];
      v6 = ok && q[3] && q[0];
      ctrl[7:4] = ctrl[7:4] | {nsOk, arpOk, v6, v4};
      if (nsOk) naExp = ctrl[8] ? (hit[0] ? sets[0] : sets[1]) : tg;
      chk(nsAnswerReq, nsOk);
      chk(nsSetHit, nsOk ? hit : 2'h0);
      chk(arpAnswerReq, arpOk && ctrl[2]);
      chk(wakeReq, (v4 && ctrl[0]) || (v6 && ctrl[1]));
      chk(fwdPass, (nsOk && ctrl[9]) || (arpOk && ctrl[2] && ctrl[10]));
      chk(fwdDrop, (nsOk && !ctrl[9]) || (arpOk && ctrl[2] && !ctrl[10]));
      chk(naSourceAddr, naExp);
      rdc(`WONM_OFS_CTRL, ctrl);
    end
  endtask

  initial begin
    void'($urandom(76));
    rst_n = 1'b0;
    resumeDone = 1'b0;
    s_axi_awaddr = 12'h0;
    s_axi_araddr = 12'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    ctrl = 32'h0;
    aux = 32'h0;
    sets = '{128'h0, 128'h0};
    naExp = 128'h0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    // reset values, unmapped and misaligned places
    rdc(`WONM_OFS_CTRL, 32'h0);
    rdc(`WONM_OFS_NS1 + 12'hC, 32'h0);
    rdc(12'h700, 32'h0);
    wr(12'h612, 32'hFFFFFFFF);
    wr(`WONM_OFS_CTRL, 32'hFFFFFFFF);
    rdc(`WONM_OFS_CTRL, ctrl);
    // program both address sets, lowest dword at lowest offset
    for (i = 0; i < 8; i++)
      wr((i < 4 ? `WONM_OFS_NS0 : `WONM_OFS_NS1 - 12'h10) + 12'(4 * i), $urandom);
    for (i = 0; i < 8; i++)
      rdc((i < 4 ? `WONM_OFS_NS0 : `WONM_OFS_NS1 - 12'h10) + 12'(4 * i),
        sets[i / 4][32 * (i % 4) +: 32]);
    // random frames against exact, solicited and foreign addresses
    for (i = 0; i < 80; i++) begin
      if (i % 4 == 0) wr(`WONM_OFS_CTRL, $urandom | {28'h0, i[3], 3'h0});
      sel = $urandom % 5;
      da = sel == 4 ? {$urandom, $urandom, $urandom, $urandom} :
        sel > 1 ? {`WONM_SOL_PREFIX, sets[sel - 2][127:104]} : sets[sel];
      // at most one frame type per frame; odd frames are NS
      qRand = 13'($urandom);
      qRand[6:3] = i[0] ? 4'h4 : 4'(5'h01 << ($urandom % 5));
      frm(da, qRand | (i[0] ? 13'h1222 : 13'h0), {$urandom, $urandom, $urandom, $urandom});
      if (i % 8 == 7) begin
        wr(`WONM_OFS_AUX, $urandom);
        rdc(`WONM_OFS_AUX, aux);
        @(posedge ref_clk);
        resumeDone <= 1'b1;
        @(posedge ref_clk);
        resumeDone <= 1'b0;
        if (aux[0]) ctrl[5:4] = 2'h0;
        if (aux[1]) ctrl[1:0] = 2'h0;
        rdc(`WONM_OFS_CTRL, ctrl);
      end
    end
    give_verdict;
  end
endmodule
